// File: core/pcs_compare_stage.sv
// pwm base counter, four comparators, pending bits and register file
`timescale 1ns/10ps
`default_nettype none
// Register map, byte offsets
// 0x00 configuration: scale shift, hold-pending, auto-zero, glitch
//      guard, run enables, center align, pair links, pending bits
// 0x08 base counter, compare width plus fifteen bits
// 0x10 scaled count view; a write replaces the slice at scale shift
// 0x20, 0x24, 0x28, 0x2c compare values 0 to 3
// all other offsets read as zero and ignore writes
//
// Limitations
// centered waves are symmetric only over the full scaled period
// a restart with auto-zero off needs the counter to be running
// software writes to counter or scaled view beat counting and clears
// hardware-set pending bits win over a clearing configuration write
// pad inversion for left-aligned waves is left to the pad logic
// single run stops counting after its first restart
//
module pcs_compare_stage #(
    parameter int CMP_W = pcs_pkg::CMP_W
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic [3:0] PAD_OUTPUT,
    output logic [3:0] IRQ
);

    localparam int CNT_W = CMP_W + 15;

    // one-hot register select positions, compare values take four
    localparam int SEL_CFG = 0;
    localparam int SEL_CNT = 1;
    localparam int SEL_SCL = 2;
    localparam int SEL_CMP = 3;
    localparam pcs_pkg::pcs_config_s CFG_RST =
        pcs_pkg::pcs_config_s'(pcs_pkg::CONFIG_RST);

    // decodes one register offset for the current request
    function automatic logic hit_ofs(input pcs_pkg::pcs_req_s q,
                                     input logic [7:0] ofs);
        hit_ofs = q.addr == ofs;
    endfunction

    // strips the reserved fields from a configuration word
    function automatic pcs_pkg::pcs_config_s cfg_clean(
        input pcs_pkg::pcs_config_s c);
        cfg_clean = c;
        cfg_clean.rsv_23_20 = 4'h0;
        cfg_clean.rsv_15_14 = 2'h0;
        cfg_clean.rsv_11 = 1'b0;
        cfg_clean.rsv_7_4 = 4'h0;
    endfunction

    pcs_pkg::pcs_req_s req;
    pcs_pkg::pcs_config_s cfg_r;
    pcs_pkg::pcs_config_s cfg_w;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CMP_W-1:0] cmp_r [4];
    logic [31:0] rdata_r;
    logic [3:0] pend_r;
    logic [3:0] pend_nxt;
    logic [3:0] pend_set;
    logic [CMP_W-1:0] scaled;
    logic [CNT_W-1:0] low_mask;
    logic [CNT_W-1:0] slice_mask;
    logic low_full;
    logic counting;
    logic carry_out;
    logic restart;
    logic restart_d_r;
    logic [3:0] hit;
    logic [3:0] cmp_wr;
    logic [6:0] sel;
    logic cfg_wr;
    logic cnt_wr;
    logic scl_wr;

    // bundle the bus request
    assign req.wr = REG_WR;
    assign req.rd = REG_RD;
    assign req.addr = REG_ADDR;
    assign req.wdata = REG_WDATA;
    assign cfg_w = cfg_clean(pcs_pkg::pcs_config_s'(REG_WDATA));

    // scaled count window taken from the base counter
    assign scaled = CMP_W'(count_r >> cfg_r.scale_shift);
    assign slice_mask = CNT_W'({CMP_W{1'b1}});
    assign low_mask = (CNT_W'(1) << cfg_r.scale_shift) - CNT_W'(1);
    assign low_full = (count_r & low_mask) == low_mask;

    // counter runs on either enable
    assign counting = cfg_r.run_always | cfg_r.run_once;

    // carry out of the scaled incrementer just before it wraps
    assign carry_out = counting & (&scaled) & low_full;

    // end of pwm cycle: value 0 match or natural wrap
    assign restart = cfg_r.auto_zero ? hit[0] : carry_out;

    // comparators, one per channel
    generate
        for (genvar i = 0; i < 4; i++) begin : g_cmp
            logic [CMP_W-1:0] view;
            // inverted count in the upper half when centered
            assign view = (cfg_r.center_align[i] && scaled[CMP_W-1]) ?
                ~scaled : scaled;
            // at or above the value raises the comparator output
            assign hit[i] = view >= cmp_r[i];
        end
    endgenerate

    // next pending state per channel
    generate
        for (genvar i = 0; i < 4; i++) begin : g_pend
            localparam int J = (i + 1) % 4;
            logic latch;
            logic keep;
            // guard holds the bit except right after a restart, and lets
            // a centered channel fall only in the second half
            assign latch = cfg_r.glitch_guard & ~restart_d_r &
                ~(cfg_r.center_align[i] & scaled[CMP_W-1]);
            // hold-pending never lets hardware drop a set bit
            assign keep = pend_r[i] & cfg_r.hold_pending;
            always_comb begin
                if (cfg_r.pair_link[i]) begin
                    // set by own match, cleared by the next comparator
                    pend_set[i] = hit[i] & ~hit[J];
                    pend_nxt[i] = pend_set[i] | (pend_r[i] & ~hit[J]) |
                        keep;
                end else begin
                    pend_set[i] = hit[i];
                    pend_nxt[i] = hit[i] | (pend_r[i] & latch) | keep;
                end
            end
        end
    endgenerate

    // restart seen one cycle ago opens the pending bits to new values
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            restart_d_r <= 1'b0;
        end else begin
            restart_d_r <= restart & cfg_r.glitch_guard;
        end
    end

    // register select, one bit per mapped offset; holes select nothing
    always_comb begin
        sel = 7'h00;
        if (hit_ofs(req, pcs_pkg::OFS_CONFIG)) begin
            sel[SEL_CFG] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_COUNT)) begin
            sel[SEL_CNT] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_SCALED)) begin
            sel[SEL_SCL] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_CMP0)) begin
            sel[SEL_CMP] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_CMP1)) begin
            sel[SEL_CMP + 1] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_CMP2)) begin
            sel[SEL_CMP + 2] = 1'b1;
        end else if (hit_ofs(req, pcs_pkg::OFS_CMP3)) begin
            sel[SEL_CMP + 3] = 1'b1;
        end
    end

    // write strobes for configuration, counter and scaled view
    assign cfg_wr = req.wr & sel[SEL_CFG];
    assign cnt_wr = req.wr & sel[SEL_CNT];
    assign scl_wr = req.wr & sel[SEL_SCL];

    // per-channel write strobes for compare values
    generate
        for (genvar i = 0; i < 4; i++) begin : g_cmpwr
            assign cmp_wr[i] = req.wr & sel[SEL_CMP + i];
        end
    endgenerate

    // compare value registers, upper bits are not stored
    generate
        for (genvar i = 0; i < 4; i++) begin : g_cmpreg
            always_ff @(posedge CLOCK) begin
                if (RESET) begin
                    cmp_r[i] <= pcs_pkg::CMP_RST;
                end else if (cmp_wr[i]) begin
                    cmp_r[i] <= req.wdata[CMP_W-1:0];
                end
            end
        end
    endgenerate

    // base counter next value; software writes win over counting
    always_comb begin
        count_nxt = count_r;
        // a direct counter write replaces every counter bit
        if (cnt_wr) begin
            count_nxt = req.wdata[CNT_W-1:0];
        end else if (scl_wr) begin
            // a scaled view write keeps the bits outside the slice
            count_nxt = (count_r & ~(slice_mask << cfg_r.scale_shift)) |
                (CNT_W'(req.wdata[CMP_W-1:0]) << cfg_r.scale_shift);
        end else if (cfg_r.auto_zero && hit[0]) begin
            count_nxt = '0;
        end else if (counting) begin
            count_nxt = count_r + CNT_W'(1);
        end
    end

    // base counter register
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            count_r <= pcs_pkg::COUNT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // configuration register; pending bits set by hardware win over
    // a software clear arriving in the same cycle
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfg_r <= CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= cfg_w;
            cfg_r.compare_pending <= cfg_w.compare_pending | pend_set;
        end else begin
            cfg_r.compare_pending <= pend_nxt;
            if (restart) begin
                cfg_r.run_once <= 1'b0;
            end
        end
    end

    // pending bits live in the top field of the configuration register
    assign pend_r = cfg_r.compare_pending;

    // registered read data; unmapped offsets read zero
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rdata_r <= 32'h0000_0000;
        end else if (req.rd) begin
            if (hit_ofs(req, pcs_pkg::OFS_CONFIG)) begin
                rdata_r <= 32'(cfg_r);
            end else if (hit_ofs(req, pcs_pkg::OFS_COUNT)) begin
                rdata_r <= 32'(count_r);
            end else if (hit_ofs(req, pcs_pkg::OFS_SCALED)) begin
                rdata_r <= 32'(scaled);
            end else if (hit_ofs(req, pcs_pkg::OFS_CMP0)) begin
                rdata_r <= 32'(cmp_r[0]);
            end else if (hit_ofs(req, pcs_pkg::OFS_CMP1)) begin
                rdata_r <= 32'(cmp_r[1]);
            end else if (hit_ofs(req, pcs_pkg::OFS_CMP2)) begin
                rdata_r <= 32'(cmp_r[2]);
            end else if (hit_ofs(req, pcs_pkg::OFS_CMP3)) begin
                rdata_r <= 32'(cmp_r[3]);
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    // outputs straight from flops
    assign REG_RDATA = rdata_r;
    assign PAD_OUTPUT = pend_r;
    assign IRQ = pend_r;

endmodule
`default_nettype wire

// File: core/pcs_pkg.sv
// shared constants and types for the pwm compare and output stage
package pcs_pkg;

    // default compare width and base counter width
    localparam int CMP_W = 16;
    localparam int CNT_W = CMP_W + 15;
    localparam int NCMP = 4;

    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_SCALED = 8'h10;
    localparam logic [7:0] OFS_CMP0 = 8'h20;
    localparam logic [7:0] OFS_CMP1 = 8'h24;
    localparam logic [7:0] OFS_CMP2 = 8'h28;
    localparam logic [7:0] OFS_CMP3 = 8'h2c;

    // reset values
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [CMP_W-1:0] CMP_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RST = 31'h0000_0000;

    // configuration register layout, msb first
    typedef struct packed {
        logic [3:0] compare_pending;  // bits 31:28
        logic [3:0] pair_link;        // bits 27:24
        logic [3:0] rsv_23_20;
        logic [3:0] center_align;     // bits 19:16
        logic [1:0] rsv_15_14;
        logic run_once;               // bit 13
        logic run_always;             // bit 12
        logic rsv_11;
        logic glitch_guard;           // bit 10
        logic auto_zero;              // bit 9
        logic hold_pending;           // bit 8
        logic [3:0] rsv_7_4;
        logic [3:0] scale_shift;      // bits 3:0
    } pcs_config_s;

    // register access request from the bus side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pcs_req_s;

endpackage

// File: bench/pcs_monitor.sv
// port checker for the pwm compare and output stage
`timescale 1ns/10ps
`default_nettype none
module pcs_monitor (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic [3:0] PAD_OUTPUT,
    input wire logic [3:0] IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // interrupt lines mirror the pending bits seen at the pads
    property p_irq_pad;
        IRQ == PAD_OUTPUT;
    endproperty
    a_irq_pad: assert property (p_irq_pad) else $error("irq differs from pad");
    // reset leaves pads and read data low
    property p_reset;
        disable iff (1'b0) RESET |=> PAD_OUTPUT == 4'h0 && REG_RDATA == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    // compare value upper bits read as zero
    property p_cmp_rsv;
        REG_RD && REG_ADDR[7:4] == 4'h2 && REG_ADDR[1:0] == 2'b00
            |=> REG_RDATA[31:16] == 16'h0;
    endproperty
    a_cmp_rsv: assert property (p_cmp_rsv) else $error("compare upper bits");
    // scaled count upper bits read as zero
    property p_scaled_rsv;
        REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA[31:16] == 16'h0;
    endproperty
    a_scaled_rsv: assert property (p_scaled_rsv) else $error("scaled upper bits");
    // a hole in the map reads zero
    property p_unmapped;
        REG_RD && REG_ADDR == 8'h04 |=> REG_RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    // pending field read back equals the pad outputs of that cycle
    property p_cfg_pend;
        REG_RD && !REG_WR && REG_ADDR == 8'h00
            |=> REG_RDATA[31:28] == $past(PAD_OUTPUT);
    endproperty
    a_cfg_pend: assert property (p_cfg_pend) else $error("pending readback");
    // reserved configuration bits read zero
    property p_cfg_rsv;
        REG_RD && REG_ADDR == 8'h00 |=> (REG_RDATA & 32'h00f0_c8f0) == 32'h0;
    endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved bits");
    // read data holds between reads
    property p_rdata_hold;
        !REG_RD |=> $stable(REG_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // main scenarios reached
    c_pad_rise: cover property ($rose(PAD_OUTPUT[0]));
    c_all_irq: cover property (IRQ == 4'hf);
    c_scaled_rd: cover property (REG_RD && REG_ADDR == 8'h10);
endmodule
`default_nettype wire

// File: bench/pcs_pad_model.sv
// pad side model: per-pad optional inversion of the pending outputs
`timescale 1ns/10ps
`default_nettype none
module pcs_pad_model (
    input wire logic [3:0] pad_output,
    input wire logic [3:0] invert,
    output logic [3:0] pad_level
);
    // inverting a pad turns a right-aligned wave left-aligned
    assign pad_level = pad_output ^ invert;
endmodule
`default_nettype wire

// File: bench/pwm_compare_output_stage_tb_top.sv
// self-checking bench for the pwm compare and output stage
`timescale 1ns/10ps
`default_nettype none
module pwm_compare_output_stage_tb_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [3:0] pad_output;
    logic [3:0] irq;
    logic [3:0] pad_level;
    logic [3:0] inv = 4'h3;
    int num_errors = 0;
    int tests_run = 0;
    // 50 MHz clock
    always #10 clock = ~clock;
    pcs_compare_stage u_dut (.CLOCK(clock), .RESET(reset), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .PAD_OUTPUT(pad_output), .IRQ(irq));
    pcs_pad_model u_pad (.pad_output(pad_output), .invert(inv),
        .pad_level(pad_level));
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one write strobe, then an idle edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    // one read strobe, data judged mid-cycle after the taking edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check(what, exp, reg_rdata);
        @(posedge clock);
    endtask
    task automatic s_regs();
        for (int i = 0; i < 4; i++) begin
            wr(8'h20 + 8'(4 * i), 32'hffff_1230 + 32'(i));
            rd(8'h20 + 8'(4 * i), 32'h1230 + 32'(i), "compare");
        end
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h0, "unmapped");
    endtask
    task automatic s_scaled();
        wr(8'h00, 32'h4);
        wr(8'h08, 32'h340);
        rd(8'h10, 32'h34, "scaled by 4");
        wr(8'h00, 32'h0);
        rd(8'h10, 32'h340, "scaled by 0");
    endtask
    // counts the cycles out of fourteen in which one irq line is high
    task automatic count_irq(input int ch, output int ones);
        ones = 0;
        repeat (14) begin
            @(negedge clock);
            ones += int'(irq[ch]);
            @(posedge clock);
        end
    endtask
    // pair link 3: set from count 2, cleared by comparator 0 at count 6
    task automatic s_pair();
        int ones;
        wr(8'h2c, 32'h2);
        wr(8'h00, 32'h0800_1200);
        repeat (3) @(posedge clock);
        count_irq(3, ones);
        check("pair link ones", 32'd8, 32'(ones));
        wr(8'h00, 32'h0);
    endtask
    // guard holds pending bits until the carry out of the scaled count
    task automatic s_guard();
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h400);
        wr(8'h2c, 32'h0);
        wr(8'h2c, 32'h7);
        @(negedge clock);
        check("guard latch", 32'h8, 32'(irq));
        @(posedge clock);
        wr(8'h08, 32'hfff8);
        wr(8'h00, 32'h1400);
        repeat (9) @(posedge clock);
        @(negedge clock);
        check("guard restart", 32'h0, 32'(irq));
        @(posedge clock);
        rd(8'h08, 32'h1_0003, "wrapped count");
        wr(8'h00, 32'h0);
    endtask
    // guard with auto-zero: pending 0 high one cycle per period of seven
    task automatic s_pulse();
        int ones;
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h1600);
        repeat (3) @(posedge clock);
        count_irq(0, ones);
        check("pending 0 pulses", 32'd2, 32'(ones));
        wr(8'h00, 32'h0);
    endtask
    // centered channel 2 compares the inverted count in the upper half
    task automatic s_center();
        wr(8'h08, 32'h8001);
        wr(8'h28, 32'h7fff);
        @(negedge clock);
        check("uncentered", 32'hf, 32'(irq));
        @(posedge clock);
        wr(8'h00, 32'h0004_0000);
        @(negedge clock);
        check("centered", 32'hb, 32'(irq));
        @(posedge clock);
    endtask
    // period of seven: pads 0 and 1 inverted at the pad side
    task automatic s_autozero();
        int hits[4] = '{0, 0, 0, 0};
        wr(8'h20, 32'h6);
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h7);
        wr(8'h2c, 32'h3);
        wr(8'h00, 32'h1200);
        repeat (3) @(posedge clock);
        repeat (14) begin
            @(negedge clock);
            for (int i = 0; i < 4; i++) hits[i] += int'(pad_level[i]);
            @(posedge clock);
        end
        check("pad0 ones", 32'd12, 32'(hits[0]));
        check("pad1 ones", 32'd0, 32'(hits[1]));
        check("pad2 ones", 32'd0, 32'(hits[2]));
        check("pad3 ones", 32'd8, 32'(hits[3]));
    endtask
    task automatic s_oneshot();
        wr(8'h00, 32'h2200);
        repeat (10) @(posedge clock);
        rd(8'h00, 32'h2000_0200, "single run");
        rd(8'h08, 32'h0, "stopped count");
    endtask
    task automatic s_clear();
        wr(8'h24, 32'h5);
        @(negedge clock);
        check("no hits", 32'h0, 32'(irq));
        @(posedge clock);
        wr(8'h00, 32'hf000_0100);
        repeat (3) @(posedge clock);
        @(negedge clock);
        check("held", 32'hf, 32'(irq));
        check("pad level", 32'(4'hf ^ inv), 32'(pad_level));
        @(posedge clock);
        wr(8'h00, 32'h0);
        @(negedge clock);
        check("cleared", 32'h0, 32'(irq));
        @(posedge clock);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        s_regs();
        s_scaled();
        s_autozero();
        s_oneshot();
        s_clear();
        s_pair();
        s_guard();
        s_pulse();
        s_center();
        complete_run();
    end
    // cut a hang short
    initial begin
        repeat (2000) @(posedge clock);
        num_errors++;
        complete_run();
    end
endmodule
bind pcs_compare_stage pcs_monitor u_mon (.CLOCK(CLOCK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PAD_OUTPUT(PAD_OUTPUT), .IRQ(IRQ));
`default_nettype wire
